// ==== design/gc_cmd_pkg.sv ====
// constants shared by the general call command decoder
// Overview of operation
// - general call then 0x06: pulse chip soft reset and empty all buffers
// - general call then 0x0E: discard transmit and receive buffer contents
// - general call then 0x0C: next own-address read returns bytes ready count
// - reported available count saturates at 0xFF meaning 255 or more
// - general call then 0x16: next own-address read returns USB state code
// - USB state code: 0 suspended, 1 default, 2 addressed, 3 configured
// - identity is three bytes: 12-bit maker, 9-bit part, 3-bit revision
// - while master acknowledges, identity bytes repeat cyclically
// - after power-on or USB reset, load configuration from nonvolatile store
// - if enabled, pull down bus pins and pin zero during USB suspend
// - by default pin zero is a stay-awake input blocking suspend
// - read of own address with empty transmit buffer and no pending query result gets no acknowledge
package gc_cmd_pkg;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [6:0] ID_CMD_ADDR = 7'h3E;
   localparam logic [6:0] DEF_SLAVE_ADDR = 7'h22;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
   localparam logic [7:0] CMD_FLUSH = 8'h0E;
   localparam logic [7:0] CMD_DATA_AVAIL = 8'h0C;
   localparam logic [7:0] CMD_USB_STATE = 8'h16;
   localparam logic [7:0] COUNT_SAT = 8'hFF;
   localparam logic [1:0] USB_SUSPENDED = 2'h0;
   localparam logic [1:0] USB_DEFAULT = 2'h1;
   localparam logic [1:0] USB_ADDRESSED = 2'h2;
   localparam logic [1:0] USB_CONFIGURED = 2'h3;
   localparam logic [1:0] ID_LAST_IDX = 2'h2;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic DEF_PULLDOWN_EN = 1'b0;
   localparam logic DEF_KEEP_AWAKE_EN = 1'b1;
   typedef enum {S_IDLE, S_ADDR, S_WR, S_ACK, S_RD, S_RACK} bus_state_t;
   typedef enum {M_NONE, M_GC, M_IDW, M_OWN_W, M_RD_BUF, M_RD_Q, M_RD_ID} mode_t;
endpackage

// ==== design/pin_sync.sv ====
// two-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_dout;

   // first stage feeds only the second stage
   always_comb begin
      next_meta = din;
      next_dout = meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end
endmodule
`default_nettype wire

// ==== design/gc_cmd_decoder.sv ====
// i2c slave command decoder: general call commands, identity read, buffer access
`timescale 1ns/1ps
`default_nettype none
module gc_cmd_decoder #(
   parameter int CNT_W = 10,
   parameter logic [11:0] MAKER_CODE = 12'h5A5, // arbitrary value
   parameter logic [8:0] PART_CODE = 9'h0C3, // arbitrary value
   parameter logic [2:0] REV_CODE = 3'h1 // arbitrary value
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic config_pin_zero_in,
   output logic config_pin_zero_out,
   output logic config_pin_zero_oe,
   input wire logic [7:0] tx_data,
   input wire logic [CNT_W-1:0] tx_count,
   input wire logic tx_empty,
   output logic tx_pop,
   output logic [7:0] rx_data,
   output logic rx_push,
   input wire logic rx_full,
   output logic flush,
   output logic soft_reset,
   input wire logic [1:0] usb_state,
   input wire logic usb_reset,
   input wire logic power_enable_out_n,
   output logic nv_load_req,
   input wire logic nv_load_done,
   input wire logic [6:0] nv_slave_addr,
   input wire logic nv_pulldown_en,
   input wire logic nv_keep_awake_en,
   output logic stay_awake
);
   if (CNT_W < 8) begin : g_bad_width
      $error("CNT_W must be at least 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus edge detection
   logic [2:0] pins_s;
   logic scl_d, sda_d, next_scl_d, next_sda_d;
   pin_sync #(.W(3), .RST_VAL(3'b111)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din({scl_in, sda_in, config_pin_zero_in}),
      .dout(pins_s)
   );
   wire scl_s = pins_s[2];
   wire sda_s = pins_s[1];
   wire pin0_s = pins_s[0];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

   // saturating available count, used at command time
   function automatic logic [7:0] sat_count(input logic [CNT_W-1:0] c);
      if (c > CNT_W'(gc_cmd_pkg::COUNT_SAT)) return gc_cmd_pkg::COUNT_SAT;
      return c[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration loading, suspend pull-down and stay-awake
   logic [6:0] own_addr, next_own_addr;
   logic pd_en, next_pd_en, keep_en, next_keep_en;
   logic next_nv_load_req, pd_active, next_pd_active, next_stay_awake;

   // reload after reset, usb reset or soft reset; defaults hold until done
   always_comb begin
      next_nv_load_req = usb_reset | soft_reset;
      next_own_addr = own_addr;
      next_pd_en = pd_en;
      next_keep_en = keep_en;
      if (nv_load_done) begin
         next_own_addr = nv_slave_addr;
         next_pd_en = nv_pulldown_en;
         next_keep_en = nv_keep_awake_en;
      end
      next_pd_active = pd_en & power_enable_out_n;
      next_stay_awake = keep_en & ~pin0_s;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nv_load_req <= 1'b1;
         own_addr <= gc_cmd_pkg::DEF_SLAVE_ADDR;
         pd_en <= gc_cmd_pkg::DEF_PULLDOWN_EN;
         keep_en <= gc_cmd_pkg::DEF_KEEP_AWAKE_EN;
         pd_active <= 1'b0;
         stay_awake <= 1'b0;
      end else begin
         nv_load_req <= next_nv_load_req;
         own_addr <= next_own_addr;
         pd_en <= next_pd_en;
         keep_en <= next_keep_en;
         pd_active <= next_pd_active;
         stay_awake <= next_stay_awake;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus engine and command decode
   gc_cmd_pkg::bus_state_t state, next_state;
   gc_cmd_pkg::mode_t mode, next_mode;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shift, next_shift, pend_byte, next_pend_byte, next_rx_data;
   logic [1:0] id_idx, next_id_idx;
   logic drive, next_drive, id_armed, next_id_armed, pend_valid, next_pend_valid;
   logic next_tx_pop, next_rx_push, next_flush, next_soft_reset;
   logic byte_in, is_rd, ack;
   logic [6:0] addr7;
   logic [23:0] id_word;
   logic [7:0] load_byte;

   assign id_word = {MAKER_CODE, PART_CODE, REV_CODE};
   assign byte_in = scl_fall & (bit_cnt == gc_cmd_pkg::BITS_PER_BYTE);
   assign addr7 = shift[7:1];
   assign is_rd = shift[0];

   always_comb begin
      next_state = state;
      next_mode = mode;
      next_bit_cnt = bit_cnt;
      next_shift = shift;
      next_pend_byte = pend_byte;
      next_pend_valid = pend_valid;
      next_id_idx = id_idx;
      next_id_armed = id_armed;
      next_drive = drive;
      next_rx_data = rx_data;
      next_tx_pop = 1'b0;
      next_rx_push = 1'b0;
      next_flush = 1'b0;
      next_soft_reset = 1'b0;
      ack = 1'b0;
      load_byte = tx_data;
      case (state)
         gc_cmd_pkg::S_IDLE: begin
         end
         gc_cmd_pkg::S_ADDR, gc_cmd_pkg::S_WR: begin
            if (scl_rise) begin
               next_shift = {shift[6:0], sda_s};
               next_bit_cnt = bit_cnt + 4'h1;
            end
            if (byte_in && state == gc_cmd_pkg::S_ADDR) begin
               if (addr7 == gc_cmd_pkg::GC_ADDR && !is_rd) begin
                  ack = 1'b1;
                  next_mode = gc_cmd_pkg::M_GC;
               end else if (addr7 == gc_cmd_pkg::ID_CMD_ADDR && !is_rd) begin
                  ack = 1'b1;
                  next_mode = gc_cmd_pkg::M_IDW;
               end else if (addr7 == gc_cmd_pkg::ID_CMD_ADDR && id_armed) begin
                  ack = 1'b1;
                  next_mode = gc_cmd_pkg::M_RD_ID;
                  next_id_idx = 2'h0;
               end else if (addr7 == own_addr && !is_rd) begin
                  ack = !rx_full;
                  next_mode = gc_cmd_pkg::M_OWN_W;
               end else if (addr7 == own_addr && pend_valid) begin
                  ack = 1'b1;
                  next_mode = gc_cmd_pkg::M_RD_Q;
               end else if (addr7 == own_addr) begin
                  ack = !tx_empty;
                  next_mode = gc_cmd_pkg::M_RD_BUF;
               end
            end else if (byte_in) begin
               case (mode)
                  gc_cmd_pkg::M_GC: begin
                     ack = 1'b1;
                     next_mode = gc_cmd_pkg::M_NONE;
                     case (shift)
                        gc_cmd_pkg::CMD_SOFT_RESET: begin
                           next_soft_reset = 1'b1;
                           next_flush = 1'b1;
                           next_pend_valid = 1'b0;
                        end
                        gc_cmd_pkg::CMD_FLUSH: next_flush = 1'b1;
                        gc_cmd_pkg::CMD_DATA_AVAIL: begin
                           next_pend_byte = sat_count(tx_count);
                           next_pend_valid = 1'b1;
                        end
                        gc_cmd_pkg::CMD_USB_STATE: begin
                           next_pend_byte = {6'h00, usb_state};
                           next_pend_valid = 1'b1;
                        end
                        default: begin
                        end
                     endcase
                  end
                  gc_cmd_pkg::M_IDW: begin
                     // direction bit of the own address is ignored
                     ack = (addr7 == own_addr);
                     next_id_armed = ack;
                  end
                  gc_cmd_pkg::M_OWN_W: begin
                     ack = !rx_full;
                     next_rx_push = !rx_full;
                     next_rx_data = shift;
                  end
                  default: ack = 1'b0;
               endcase
            end
            if (byte_in) begin
               next_drive = ack;
               next_state = ack ? gc_cmd_pkg::S_ACK : gc_cmd_pkg::S_IDLE;
            end
         end
         gc_cmd_pkg::S_ACK: begin
            // slave drives low through the ninth clock, then hands over
            if (scl_fall) begin
               if (mode == gc_cmd_pkg::M_RD_BUF || mode == gc_cmd_pkg::M_RD_Q ||
                   mode == gc_cmd_pkg::M_RD_ID) begin
                  if (mode == gc_cmd_pkg::M_RD_Q) begin
                     load_byte = pend_byte;
                     next_pend_valid = 1'b0;
                     next_mode = gc_cmd_pkg::M_RD_BUF;
                  end else if (mode == gc_cmd_pkg::M_RD_ID) begin
                     load_byte = id_word[23 - 8 * id_idx -: 8];
                     next_id_idx = (id_idx == gc_cmd_pkg::ID_LAST_IDX) ? 2'h0 : id_idx + 2'h1;
                  end else begin
                     next_tx_pop = !tx_empty;
                  end
                  next_shift = load_byte;
                  next_drive = ~load_byte[7];
                  next_bit_cnt = 4'h1;
                  next_state = gc_cmd_pkg::S_RD;
               end else begin
                  next_drive = 1'b0;
                  next_bit_cnt = 4'h0;
                  next_state = gc_cmd_pkg::S_WR;
               end
            end
         end
         gc_cmd_pkg::S_RD: begin
            if (byte_in) begin
               next_drive = 1'b0;
               next_state = gc_cmd_pkg::S_RACK;
            end else if (scl_fall) begin
               next_shift = {shift[6:0], 1'b1};
               next_drive = ~shift[6];
               next_bit_cnt = bit_cnt + 4'h1;
            end
         end
         gc_cmd_pkg::S_RACK: begin
            // a not-acknowledge from the master ends the read
            if (scl_rise) begin
               next_state = sda_s ? gc_cmd_pkg::S_IDLE : gc_cmd_pkg::S_ACK;
            end
         end
         default: next_state = gc_cmd_pkg::S_IDLE;
      endcase
      // start and stop override any phase; stop drops the identity request
      if (bus_start) begin
         next_state = gc_cmd_pkg::S_ADDR;
         next_bit_cnt = 4'h0;
         next_drive = 1'b0;
      end else if (bus_stop) begin
         next_state = gc_cmd_pkg::S_IDLE;
         next_drive = 1'b0;
         next_id_armed = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state <= gc_cmd_pkg::S_IDLE;
         mode <= gc_cmd_pkg::M_NONE;
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         pend_byte <= 8'h00;
         pend_valid <= 1'b0;
         id_idx <= 2'h0;
         id_armed <= 1'b0;
         drive <= 1'b0;
         rx_data <= 8'h00;
         tx_pop <= 1'b0;
         rx_push <= 1'b0;
         flush <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         scl_d <= next_scl_d;
         sda_d <= next_sda_d;
         state <= next_state;
         mode <= next_mode;
         bit_cnt <= next_bit_cnt;
         shift <= next_shift;
         pend_byte <= next_pend_byte;
         pend_valid <= next_pend_valid;
         id_idx <= next_id_idx;
         id_armed <= next_id_armed;
         drive <= next_drive;
         rx_data <= next_rx_data;
         tx_pop <= next_tx_pop;
         rx_push <= next_rx_push;
         flush <= next_flush;
         soft_reset <= next_soft_reset;
      end
   end

   assign next_scl_d = scl_s;
   assign next_sda_d = sda_s;

   // open-drain pins only ever pull low; suspend pull-down overrides
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign config_pin_zero_out = 1'b0;
   assign scl_oe = pd_active;
   assign sda_oe = drive | pd_active;
   assign config_pin_zero_oe = pd_active;

   ////////////////////////////////////////////////////////////////////////////
   // assertions and covers
   wire gc_cmd = byte_in && state == gc_cmd_pkg::S_WR && mode == gc_cmd_pkg::M_GC;
   wire q_load = state == gc_cmd_pkg::S_ACK && scl_fall && mode == gc_cmd_pkg::M_RD_Q;
   wire id_load = state == gc_cmd_pkg::S_ACK && scl_fall && mode == gc_cmd_pkg::M_RD_ID;

   a_soft_reset_flush: assert property (@(posedge clk) disable iff (!arst_n)
      gc_cmd && shift == gc_cmd_pkg::CMD_SOFT_RESET && !bus_start && !bus_stop |=> soft_reset && flush)
      else $error("soft reset command did not reset and flush");
   a_flush_cmd: assert property (@(posedge clk) disable iff (!arst_n)
      flush |-> $past(gc_cmd) && ($past(shift) == gc_cmd_pkg::CMD_FLUSH ||
                                  $past(shift) == gc_cmd_pkg::CMD_SOFT_RESET))
      else $error("flush without flush command");
   a_count_saturate: assert property (@(posedge clk) disable iff (!arst_n)
      gc_cmd && shift == gc_cmd_pkg::CMD_DATA_AVAIL && tx_count > CNT_W'(gc_cmd_pkg::COUNT_SAT)
      |=> pend_valid && pend_byte == 8'hFF)
      else $error("available count not saturated");
   a_usb_state_code: assert property (@(posedge clk) disable iff (!arst_n)
      gc_cmd && shift == gc_cmd_pkg::CMD_USB_STATE |=> pend_byte == {6'h00, $past(usb_state)})
      else $error("usb state byte wrong");
   a_id_wrap: assert property (@(posedge clk) disable iff (!arst_n)
      id_load && id_idx == 2'h2 && !bus_start && !bus_stop |=> id_idx == 2'h0 && shift == {PART_CODE[4:0], REV_CODE})
      else $error("identity index did not wrap");
   a_id_first_byte: assert property (@(posedge clk) disable iff (!arst_n)
      id_load && id_idx == 2'h0 && !bus_start && !bus_stop |=> shift == MAKER_CODE[11:4] ##1 drive == ~shift[7])
      else $error("identity first byte wrong");
   a_empty_nack: assert property (@(posedge clk) disable iff (!arst_n)
      byte_in && state == gc_cmd_pkg::S_ADDR && addr7 == own_addr && is_rd && tx_empty && !pend_valid
      && !bus_start && !bus_stop |=> !drive && state == gc_cmd_pkg::S_IDLE)
      else $error("empty buffer read was acknowledged");
   a_query_once: assert property (@(posedge clk) disable iff (!arst_n)
      q_load && !bus_start && !bus_stop |=> !pend_valid && mode == gc_cmd_pkg::M_RD_BUF)
      else $error("query result not consumed");
   a_nv_reload: assert property (@(posedge clk) disable iff (!arst_n)
      usb_reset |=> nv_load_req)
      else $error("no configuration reload after usb reset");
   a_addr_from_nv: assert property (@(posedge clk) disable iff (!arst_n)
      nv_load_done |=> own_addr == $past(nv_slave_addr))
      else $error("slave address not taken from configuration");
   a_suspend_pull: assert property (@(posedge clk) disable iff (!arst_n)
      pd_en && power_enable_out_n |=> scl_oe && sda_oe && config_pin_zero_oe)
      else $error("pins not pulled down in suspend");
   a_stay_awake: assert property (@(posedge clk) disable iff (!arst_n)
      keep_en && !pin0_s |=> stay_awake)
      else $error("stay awake input ignored");

   c_flush: cover property (@(posedge clk) disable iff (!arst_n) flush);
   c_query_read: cover property (@(posedge clk) disable iff (!arst_n) q_load);
   c_id_wrap: cover property (@(posedge clk) disable iff (!arst_n) id_load && id_idx == 2'h2);
   c_buf_pop: cover property (@(posedge clk) disable iff (!arst_n) tx_pop);
endmodule
`default_nettype wire

// ==== verification/i2c_master_model.sv ====
// bus master model pulling scl and sda low as open-drain lines
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   input wire logic clk,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   int ph = 4; // a third of a bit in clocks (bit is 3*ph+1), raise for a slow master
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // one clock pulse; the extra cycle after the fall keeps sda changes off the edge
   task automatic bit_cycle(output logic s);
      hold(ph);
      scl_low = 1'b0;
      hold(ph);
      s = sda;
      hold(ph);
      scl_low = 1'b1;
      hold(1);
   endtask
   // start or repeated start, waits long enough for the slave to let go of sda
   task automatic start();
      sda_low = 1'b0;
      hold(2 * ph);
      scl_low = 1'b0;
      hold(2 * ph);
      sda_low = 1'b1;
      hold(2 * ph);
      scl_low = 1'b1;
      hold(ph);
   endtask
   task automatic stop();
      sda_low = 1'b1;
      hold(ph);
      scl_low = 1'b0;
      hold(2 * ph);
      sda_low = 1'b0;
      hold(2 * ph);
   endtask
   task automatic write_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~b[i];
         bit_cycle(s);
      end
      sda_low = 1'b0;
      bit_cycle(s);
      ack = ~s;
   endtask
   task automatic read_byte(input logic nack, output logic [7:0] d);
      logic s;
      sda_low = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(s);
         d[i] = s;
      end
      sda_low = ~nack; // a no-acknowledge ends the read
      bit_cycle(s);
   endtask
endmodule
`default_nettype wire

// ==== verification/i2c_general_call_commands_tb.sv ====
// testbench for the general call command decoder
`timescale 1ns/1ps
`default_nettype none
module i2c_general_call_commands_tb;
   // identity values are arbitrary
   localparam logic [23:0] ID = {12'h5A5, 9'h0C3, 3'h1};
   typedef struct packed {logic [7:0] cmd; logic [1:0] usb; logic [9:0] cnt; logic [7:0] exp;} row_t;
   row_t rows [8] = '{'{8'h0C, 2'h3, 10'h000, 8'h00}, '{8'h0C, 2'h3, 10'h0FE, 8'hFE},
      '{8'h0C, 2'h3, 10'h0FF, 8'hFF}, '{8'h0C, 2'h3, 10'h3FF, 8'hFF}, '{8'h16, 2'h0, 10'h000, 8'h00},
      '{8'h16, 2'h1, 10'h000, 8'h01}, '{8'h16, 2'h2, 10'h000, 8'h02}, '{8'h16, 2'h3, 10'h000, 8'h03}};
   logic clk, arst_n, scl, sda, m_scl, m_sda, scl_oe, sda_oe, pz_oe, pz_drv, tx_empty, tx_pop;
   logic rx_push, rx_full, flush, soft_reset, usb_reset, pwr_n, nv_req, nv_done, pd_en, ka_en, awake;
   logic [7:0] tx_data, rx_data, last_rx, d;
   logic [9:0] tx_count;
   logic [1:0] usb_state;
   logic [6:0] nv_addr;
   logic a;
   int err_count = 0, n_tests = 0, n_fl = 0, n_sr = 0, n_nv = 0, n_push = 0, n_pop = 0;
   assign scl = ~(m_scl | scl_oe);
   assign sda = ~(m_sda | sda_oe);
   ////////////////////////////////////////////////////////////////
   i2c_master_model u_master (.clk(clk), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
   gc_cmd_decoder #(.CNT_W(10), .MAKER_CODE(ID[23:12]), .PART_CODE(ID[11:3]), .REV_CODE(ID[2:0])) u_dut (
      .clk(clk), .arst_n(arst_n), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
      .sda_oe(sda_oe), .config_pin_zero_in(pz_drv & ~pz_oe), .config_pin_zero_out(),
      .config_pin_zero_oe(pz_oe), .tx_data(tx_data), .tx_count(tx_count), .tx_empty(tx_empty),
      .tx_pop(tx_pop), .rx_data(rx_data), .rx_push(rx_push), .rx_full(rx_full), .flush(flush),
      .soft_reset(soft_reset), .usb_state(usb_state), .usb_reset(usb_reset), .power_enable_out_n(pwr_n),
      .nv_load_req(nv_req), .nv_load_done(nv_done), .nv_slave_addr(nv_addr), .nv_pulldown_en(pd_en),
      .nv_keep_awake_en(ka_en), .stay_awake(awake));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // nonvolatile store answers a load request one cycle later; pulses are counted
   always @(posedge clk) begin
      nv_done <= nv_req & arst_n;
      if (flush === 1'b1) n_fl++;
      if (soft_reset === 1'b1) n_sr++;
      if (nv_req === 1'b1) n_nv++;
      if (tx_pop === 1'b1) n_pop++;
      if (rx_push === 1'b1) begin
         n_push++;
         last_rx = rx_data;
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic gc_cmd(input logic [7:0] c);
      u_master.start();
      u_master.write_byte(8'h00, a);
      u_master.write_byte(c, a);
   endtask
   // own-address read of one byte closed by a no-acknowledge
   task automatic rd_own(input logic [6:0] ad, output logic ack);
      u_master.start();
      u_master.write_byte({ad, 1'b1}, ack);
      if (ack) u_master.read_byte(1'b1, d);
      u_master.stop();
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog at 80k clocks, several times the expected traffic
   initial begin
      #2ms;
      err_count++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      {arst_n, rx_full, usb_reset, pwr_n, pd_en, nv_done} = '0;
      {pz_drv, ka_en, tx_empty} = 3'b111;
      {tx_data, tx_count, usb_state, nv_addr} = {8'hA5, 10'h000, 2'h3, 7'h22};
      cyc(5);
      chk(8'({nv_req, sda_oe, scl_oe, awake}), 8'h08);
      arst_n = 1'b1;
      cyc(6);
      chk(8'(nv_req), 8'h00);
      tx_empty = 1'b0;
      rd_own(7'h22, a);
      chk({7'h0, a}, 8'h01);
      $display("reset test done");
      n_pop = 0;
      foreach (rows[i]) begin
         {usb_state, tx_count, tx_empty} = {rows[i].usb, rows[i].cnt, rows[i].cnt == 10'h000};
         gc_cmd(rows[i].cmd);
         rd_own(7'h22, a);
         chk({7'h0, a}, 8'h01);
         chk(d, rows[i].exp);
      end
      $display("query table done");
      chk(8'(n_pop), 8'h00);
      rd_own(7'h22, a);
      chk({7'h0, a}, 8'h00);
      {tx_empty, tx_data} = {1'b0, 8'h5C};
      rd_own(7'h22, a);
      chk(d, 8'h5C);
      chk(8'(n_pop), 8'h01);
      $display("refusal test done");
      nv_addr = 7'h35;
      {n_fl, n_sr, n_nv} = '0;
      gc_cmd(8'h06);
      u_master.stop();
      chk({n_fl[3:0], n_sr[3:0]}, 8'h11);
      chk(8'(n_nv > 0), 8'h01);
      rd_own(7'h35, a);
      chk({7'h0, a}, 8'h01);
      gc_cmd(8'h0E);
      u_master.stop();
      chk({n_fl[3:0], n_sr[3:0]}, 8'h21);
      $display("reset and flush test done");
      u_master.start();
      u_master.write_byte(8'h7C, a);
      u_master.write_byte({7'h35, 1'b1}, a);
      u_master.start();
      u_master.write_byte(8'h7D, a);
      chk({7'h0, a}, 8'h01);
      u_master.ph = 8;
      for (int i = 0; i < 7; i++) begin
         u_master.read_byte(i == 6, d);
         chk(d, ID[23 - 8 * (i % 3) -: 8]);
      end
      u_master.stop();
      u_master.ph = 4;
      $display("identity test done");
      u_master.start();
      u_master.write_byte({7'h35, 1'b0}, a);
      u_master.write_byte(8'h3C, a);
      u_master.stop();
      chk(last_rx, 8'h3C);
      pd_en = 1'b1;
      n_nv = 0;
      usb_reset = 1'b1;
      cyc(1);
      usb_reset = 1'b0;
      cyc(8);
      chk(8'(n_nv > 0), 8'h01);
      pwr_n = 1'b1;
      cyc(8);
      chk(8'({scl_oe, sda_oe, pz_oe}), 8'h07);
      pwr_n = 1'b0;
      pz_drv = 1'b0;
      cyc(8);
      chk(8'(awake), 8'h01);
      pz_drv = 1'b1;
      cyc(8);
      chk(8'({scl_oe, sda_oe, pz_oe, awake}), 8'h00);
      $display("suspend test done");
      final_report();
   end
endmodule
`default_nettype wire
